/* logic/nvicw_defs.svh */
// Purpose: Constants for the nested interrupt controller with wake logic
// Assumes: Word-wide register port on the private peripheral bus
// Notes: Offsets are full byte addresses on that bus
//
// Operation
// - Set-enable register: write 1 enables, 0 ignored, read shows enables.
// - Each of the 32 interrupts holds a priority level 0 to 3.
// - Lower numeric level is more urgent; level 0 beats all.
// - Inputs accepted as held levels or as single-cycle pulses.
// - Pending and enabled interrupt becomes active by relative priority.
// - Disabled input still sets pending but never becomes active.
// - State is saved on entry and restored on exit by hardware.
// - Wait-for-interrupt sleeps until exception or preempting pending interrupt.
// - Debug entry request also ends wait-for-interrupt sleep.
// - Wait-for-interrupt sleep is only a power saving, may act as no-op.
// - Wait-for-event never stalls in this variant.
// - Send-event sets local event register and signals other processors.
// - Supervisor call raises its exception; immediate is passed to the handler.
// - Move-to-special-register loads mask or control; flags from source.
// - Clear-enable register: write 1 disables, 0 ignored, read shows enables.
// - Set-pending register: write 1 pends even disabled, read shows pending.
// - Clear-pending register: write 1 unpends, active untouched.
// - Priority bytes keep bits 7:6 only; word accesses only.
`ifndef NVICW_DEFS_SVH
`define NVICW_DEFS_SVH
`define NVICW_ADDR_EN_SET 32'hE000E100
`define NVICW_ADDR_EN_CLR 32'hE000E180
`define NVICW_ADDR_PEND_SET 32'hE000E200
`define NVICW_ADDR_PEND_CLR 32'hE000E280
`define NVICW_ADDR_PRIO_BASE 32'hE000E400
`define NVICW_ADDR_PRIO_LAST 32'hE000E41C
`define NVICW_RESET_WORD 32'h00000000
`define NVICW_PRIO_HI 7
`define NVICW_PRIO_LO 6
`define NVICW_NUM_IRQ 32
`define NVICW_SIZE_WORD 2'h2
`define NVICW_SPEC_MASK 2'h0
`define NVICW_SPEC_CONTROL 2'h1
`define NVICW_SPEC_FLAGS 2'h2
`define NVICW_IDLE_LEVEL 3'h4
`endif

/* logic/nvicw_pkg.sv */
// Purpose: Types for the nested interrupt controller with wake logic
// Assumes: One processor clock
// Notes: Types only; numbers live in the defs header
package nvicw_pkg;
  // Register port request from the core
  typedef struct packed {
    logic sel;
    logic wr;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } nvicw_bus_req_t;

  // Core instruction and exception strobes
  typedef struct packed {
    logic wait_for_interrupt;
    logic wait_for_event;
    logic send_event;
    logic supervisor_call;
    logic [7:0] svc_imm;
    logic move_to_special_reg;
    logic [1:0] msr_sel;
    logic [31:0] msr_val;
    logic dbg_req;
    logic ack;
    logic done;
    logic stack_done;
  } nvicw_core_t;

  typedef enum {
    NVICW_RUN,
    NVICW_STACK,
    NVICW_HANDLER,
    NVICW_UNSTACK,
    NVICW_SLEEP
  } nvicw_state_t;
endpackage

/* logic/nvicw_ctrl.sv */
// Purpose: Interrupt enables, pending, priority, arbitration and sleep/wake control
// Assumes: Register port is word-only; interrupt pins arrive from another domain
// Notes: Vector 0..31 are peripheral lines; NMI reported on its own output
`include "nvicw_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module nvicw_ctrl
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [31:0] i_irq,
  input wire logic [31:0] i_irq_pulse_mode,
  input wire logic i_nmi,
  input wire nvicw_pkg::nvicw_bus_req_t i_bus,
  input wire nvicw_pkg::nvicw_core_t i_core,
  output logic [31:0] o_rdata,
  output logic o_bus_err,
  output logic o_irq_take,
  output logic [4:0] o_irq_vec,
  output logic o_nmi_take,
  output logic o_svc_take,
  output logic [7:0] o_svc_imm,
  output logic o_stack_push,
  output logic o_stack_pop,
  output logic o_chain,
  output logic o_sleeping,
  output logic o_event_out,
  output logic o_event_reg,
  output logic o_mask_bit,
  output logic [1:0] o_control,
  output logic [3:0] o_flags
);
  import nvicw_pkg::*;

  // Pick the most urgent pending and enabled line; ties go to lower number
  function automatic logic [5:0] pick(input logic [31:0] cand, input logic [63:0] pr);
    logic [2:0] best;
    logic [4:0] idx;
    logic hit;
    best = `NVICW_IDLE_LEVEL;
    idx = 5'h00;
    hit = 1'b0;
    for (int k = 0; k < `NVICW_NUM_IRQ; k++)
    begin
      if (cand[k] && ({1'b0, pr[2*k +: 2]} < best))
      begin
        best = {1'b0, pr[2*k +: 2]};
        idx = 5'(k);
        hit = 1'b1;
      end
    end
    pick = {hit, idx};
  endfunction

  // Pin synchronisers: two flops before any logic
  logic [31:0] irq_s1_q, irq_s2_q, irq_prev_q;
  logic nmi_s1_q, nmi_s2_q, nmi_prev_q;
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      irq_s1_q <= 32'h00000000;
      irq_s2_q <= 32'h00000000;
      irq_prev_q <= 32'h00000000;
      nmi_s1_q <= 1'b0;
      nmi_s2_q <= 1'b0;
      nmi_prev_q <= 1'b0;
    end
    else
    begin
      irq_s1_q <= i_irq;
      irq_s2_q <= irq_s1_q;
      irq_prev_q <= irq_s2_q;
      nmi_s1_q <= i_nmi;
      nmi_s2_q <= nmi_s1_q;
      nmi_prev_q <= nmi_s2_q;
    end
  end

  // Controller state
  logic [31:0] en_q, en_d, pend_q, pend_d, act_q, act_d;
  logic [63:0] prio_q, prio_d;
  logic [31:0] rdata_q, rdata_d;
  logic err_q, err_d;
  nvicw_state_t st_q, st_d;
  logic [4:0] vec_q, vec_d;
  logic nmi_cur_q, nmi_cur_d, nmi_pend_q, nmi_pend_d;
  logic svc_pend_q, svc_pend_d;
  logic take_q, take_d, nmi_take_q, nmi_take_d, svc_take_q, svc_take_d;
  logic push_q, push_d, pop_q, pop_d, chain_q, chain_d;
  logic [7:0] imm_q, imm_d;
  logic ev_out_q, ev_out_d, ev_reg_q, ev_reg_d;
  logic mask_q, mask_d;
  logic [1:0] ctl_q, ctl_d;
  logic [3:0] flg_q, flg_d;
  logic slp_q, slp_d;
  logic [31:0] rise, hw_set, cand;
  logic [5:0] win;
  logic wr_ok, rd_ok, any_exc;
  logic [2:0] pword;

  always_comb
  begin
    en_d = en_q;
    pend_d = pend_q;
    act_d = act_q;
    prio_d = prio_q;
    rdata_d = rdata_q;
    err_d = 1'b0;
    st_d = st_q;
    vec_d = vec_q;
    nmi_cur_d = nmi_cur_q;
    nmi_pend_d = nmi_pend_q;
    svc_pend_d = svc_pend_q;
    take_d = 1'b0;
    nmi_take_d = 1'b0;
    svc_take_d = 1'b0;
    push_d = 1'b0;
    pop_d = 1'b0;
    chain_d = 1'b0;
    imm_d = imm_q;
    ev_out_d = 1'b0;
    ev_reg_d = ev_reg_q;
    mask_d = mask_q;
    ctl_d = ctl_q;
    flg_d = flg_q;
    pword = i_bus.addr[4:2];
    wr_ok = i_bus.sel && i_bus.wr && (i_bus.size == `NVICW_SIZE_WORD);
    rd_ok = i_bus.sel && !i_bus.wr && (i_bus.size == `NVICW_SIZE_WORD);
    // word accesses only; others flagged as error
    if (i_bus.sel && (i_bus.size != `NVICW_SIZE_WORD))
    begin
      err_d = 1'b1;
    end
    // Register writes
    if (wr_ok)
    begin
      if (i_bus.addr == `NVICW_ADDR_EN_SET)
      begin
        en_d = en_q | i_bus.wdata;
      end
      else if (i_bus.addr == `NVICW_ADDR_EN_CLR)
      begin
        en_d = en_q & ~i_bus.wdata;
      end
      else if (i_bus.addr == `NVICW_ADDR_PEND_SET)
      begin
        pend_d = pend_q | i_bus.wdata;
      end
      else if (i_bus.addr == `NVICW_ADDR_PEND_CLR)
      begin
        pend_d = pend_q & ~i_bus.wdata;
      end
      else if (i_bus.addr >= `NVICW_ADDR_PRIO_BASE && i_bus.addr <= `NVICW_ADDR_PRIO_LAST
               && i_bus.addr[1:0] == 2'h0)
      begin
        // keep top two bits of each byte
        for (int b = 0; b < 4; b++)
        begin
          prio_d[8*pword + 2*b +: 2] = i_bus.wdata[8*b + `NVICW_PRIO_LO +: 2];
        end
      end
      else
      begin
        err_d = 1'b1;
      end
    end
    // Register reads
    if (rd_ok)
    begin
      if (i_bus.addr == `NVICW_ADDR_EN_SET || i_bus.addr == `NVICW_ADDR_EN_CLR)
      begin
        rdata_d = en_q;
      end
      else if (i_bus.addr == `NVICW_ADDR_PEND_SET || i_bus.addr == `NVICW_ADDR_PEND_CLR)
      begin
        rdata_d = pend_q;
      end
      else if (i_bus.addr >= `NVICW_ADDR_PRIO_BASE && i_bus.addr <= `NVICW_ADDR_PRIO_LAST
               && i_bus.addr[1:0] == 2'h0)
      begin
        rdata_d = `NVICW_RESET_WORD;
        for (int b = 0; b < 4; b++)
        begin
          rdata_d[8*b + `NVICW_PRIO_LO +: 2] = prio_q[8*pword + 2*b +: 2];
        end
      end
      else
      begin
        rdata_d = `NVICW_RESET_WORD;
        err_d = 1'b1;
      end
    end
    // pulse lines latch on rising edge, level lines while inactive
    rise = irq_s2_q & ~irq_prev_q;
    hw_set = (i_irq_pulse_mode & rise) | (~i_irq_pulse_mode & irq_s2_q & ~act_q);
    // hardware sets pending regardless of enable; set beats clear
    pend_d = pend_d | hw_set;
    if (nmi_s2_q && !nmi_prev_q)
    begin
      nmi_pend_d = 1'b1;
    end
    // supervisor call raises exception; immediate kept only for handler
    if (i_core.supervisor_call)
    begin
      svc_pend_d = 1'b1;
      imm_d = i_core.svc_imm;
    end
    // send-event: local register plus outgoing pulse
    if (i_core.send_event)
    begin
      ev_reg_d = 1'b1;
      ev_out_d = 1'b1;
    end
    // wait-for-event completes at once, only consuming the event flag
    if (i_core.wait_for_event && !i_core.send_event)
    begin
      ev_reg_d = 1'b0;
    end
    // special register load; flags taken straight from the source
    if (i_core.move_to_special_reg)
    begin
      case (i_core.msr_sel)
        `NVICW_SPEC_MASK: mask_d = i_core.msr_val[0];
        `NVICW_SPEC_CONTROL: ctl_d = i_core.msr_val[1:0];
        `NVICW_SPEC_FLAGS: flg_d = i_core.msr_val[31:28];
        default: flg_d = flg_q;
      endcase
    end
    // only enabled pending lines are candidates
    cand = pend_q & en_q & ~act_q;
    win = pick(cand, prio_q);
    any_exc = nmi_pend_q || svc_pend_q || (win[5] && !mask_q);
    case (st_q)
      NVICW_RUN:
      begin
        // NMI first, ignores the mask bit
        if (nmi_pend_q)
        begin
          nmi_pend_d = 1'b0;
          nmi_cur_d = 1'b1;
          nmi_take_d = 1'b1;
          // state not saved again after a chain
          push_d = !chain_q;
          st_d = chain_q ? NVICW_HANDLER : NVICW_STACK;
        end
        else if (svc_pend_q)
        begin
          svc_pend_d = 1'b0;
          svc_take_d = 1'b1;
          push_d = !chain_q;
          st_d = chain_q ? NVICW_HANDLER : NVICW_STACK;
        end
        else if (win[5] && !mask_q)
        begin
          vec_d = win[4:0];
          act_d[win[4:0]] = 1'b1;
          pend_d[win[4:0]] = hw_set[win[4:0]] && i_irq_pulse_mode[win[4:0]];
          take_d = 1'b1;
          push_d = !chain_q;
          st_d = chain_q ? NVICW_HANDLER : NVICW_STACK;
        end
        // chained candidate withdrawn meanwhile: unstack after all
        else if (chain_q)
        begin
          pop_d = 1'b1;
          st_d = NVICW_UNSTACK;
        end
        // sleep only when nothing is taken and no debug request is present
        else if (i_core.wait_for_interrupt && !i_core.dbg_req)
        begin
          st_d = NVICW_SLEEP;
        end
      end
      NVICW_SLEEP:
      begin
        // wake on exception, would-preempt pending, or debug request
        if (any_exc || win[5] || i_core.dbg_req)
        begin
          st_d = NVICW_RUN;
        end
      end
      NVICW_STACK:
      begin
        if (i_core.stack_done)
        begin
          st_d = NVICW_HANDLER;
        end
      end
      NVICW_HANDLER:
      begin
        if (i_core.done)
        begin
          if (nmi_cur_q)
          begin
            nmi_cur_d = 1'b0;
          end
          else
          begin
            act_d[vec_q] = 1'b0;
          end
          // tail-chain straight into the next handler
          if (nmi_pend_q || (cand != 32'h00000000 && !mask_q))
          begin
            chain_d = 1'b1;
            st_d = NVICW_RUN;
          end
          else
          begin
            pop_d = 1'b1;
            st_d = NVICW_UNSTACK;
          end
        end
      end
      NVICW_UNSTACK:
      begin
        if (i_core.stack_done)
        begin
          st_d = NVICW_RUN;
        end
      end
      default: st_d = NVICW_RUN;
    endcase
    // Sleep flag kept in a flop so the output has no decode behind it
    slp_d = (st_d == NVICW_SLEEP);
  end

  // all controller bits cleared by reset
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      en_q <= 32'h00000000;
      pend_q <= 32'h00000000;
      act_q <= 32'h00000000;
      prio_q <= 64'h0000000000000000;
      rdata_q <= 32'h00000000;
      err_q <= 1'b0;
      st_q <= NVICW_RUN;
      vec_q <= 5'h00;
      nmi_cur_q <= 1'b0;
      nmi_pend_q <= 1'b0;
      svc_pend_q <= 1'b0;
      take_q <= 1'b0;
      nmi_take_q <= 1'b0;
      svc_take_q <= 1'b0;
      push_q <= 1'b0;
      pop_q <= 1'b0;
      chain_q <= 1'b0;
      imm_q <= 8'h00;
      ev_out_q <= 1'b0;
      ev_reg_q <= 1'b0;
      mask_q <= 1'b0;
      ctl_q <= 2'h0;
      flg_q <= 4'h0;
      slp_q <= 1'b0;
    end
    else
    begin
      en_q <= en_d;
      pend_q <= pend_d;
      act_q <= act_d;
      prio_q <= prio_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
      st_q <= st_d;
      vec_q <= vec_d;
      nmi_cur_q <= nmi_cur_d;
      nmi_pend_q <= nmi_pend_d;
      svc_pend_q <= svc_pend_d;
      take_q <= take_d;
      nmi_take_q <= nmi_take_d;
      svc_take_q <= svc_take_d;
      push_q <= push_d;
      pop_q <= pop_d;
      chain_q <= chain_d;
      imm_q <= imm_d;
      ev_out_q <= ev_out_d;
      ev_reg_q <= ev_reg_d;
      mask_q <= mask_d;
      ctl_q <= ctl_d;
      flg_q <= flg_d;
      slp_q <= slp_d;
    end
  end

  // Outputs straight from flops
  assign o_rdata = rdata_q;
  assign o_bus_err = err_q;
  assign o_irq_take = take_q;
  assign o_irq_vec = vec_q;
  assign o_nmi_take = nmi_take_q;
  assign o_svc_take = svc_take_q;
  assign o_svc_imm = imm_q;
  assign o_stack_push = push_q;
  assign o_stack_pop = pop_q;
  assign o_chain = chain_q;
  assign o_sleeping = slp_q;
  assign o_event_out = ev_out_q;
  assign o_event_reg = ev_reg_q;
  assign o_mask_bit = mask_q;
  assign o_control = ctl_q;
  assign o_flags = flg_q;
endmodule
`default_nettype wire

/* tb/nvicw_ctrl_properties.sv */
// Purpose: Port-level checks for the interrupt controller
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every nvicw_ctrl instance
`timescale 1ns/1ns
`default_nettype none
module nvicw_ctrl_props
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire nvicw_pkg::nvicw_bus_req_t i_bus,
  input wire nvicw_pkg::nvicw_core_t i_core,
  input wire logic o_bus_err,
  input wire logic o_irq_take,
  input wire logic o_nmi_take,
  input wire logic o_svc_take,
  input wire logic [7:0] o_svc_imm,
  input wire logic o_stack_push,
  input wire logic o_chain,
  input wire logic o_sleeping,
  input wire logic o_event_out,
  input wire logic o_event_reg,
  input wire logic o_mask_bit,
  input wire logic [3:0] o_flags
);
  import nvicw_pkg::*;
  logic [7:0] imm_q;
  logic [7:0] imm_d;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // Last requested immediate, so a late entry still compares right
  always_comb
  begin
    imm_d = i_core.supervisor_call ? i_core.svc_imm : imm_q;
  end
  always_ff @(posedge i_sys_clk)
  begin
    imm_q <= i_resetn ? imm_d : 8'h00;
  end
  property p_take_mask;
    o_irq_take |-> !$past(o_mask_bit);
  endproperty
  a_take_mask: assert property (p_take_mask) else $error("irq entry while masked");
  property p_push;
    o_stack_push |-> (o_irq_take || o_nmi_take || o_svc_take);
  endproperty
  a_push: assert property (p_push) else $error("stacking without entry");
  property p_chain;
    o_chain |-> !o_stack_push ##1 !o_stack_push;
  endproperty
  a_chain: assert property (p_chain) else $error("chain restacked");
  property p_sleep;
    $rose(o_sleeping) |-> $past(i_core.wait_for_interrupt);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep without wfi");
  property p_dbg;
    o_sleeping && i_core.dbg_req |=> !o_sleeping;
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug did not wake");
  property p_wfe;
    i_core.wait_for_event && !i_core.wait_for_interrupt && !o_sleeping |=> !o_sleeping;
  endproperty
  a_wfe: assert property (p_wfe) else $error("wfe stalled");
  property p_sev;
    i_core.send_event |=> o_event_out && o_event_reg;
  endproperty
  a_sev: assert property (p_sev) else $error("send event lost");
  property p_svc;
    o_svc_take |-> o_svc_imm == imm_q;
  endproperty
  a_svc: assert property (p_svc) else $error("svc immediate wrong");
  property p_msr;
    i_core.move_to_special_reg && i_core.msr_sel == 2'h2 |=> o_flags == $past(i_core.msr_val[31:28]);
  endproperty
  a_msr: assert property (p_msr) else $error("flags not loaded");
  property p_size;
    i_bus.sel && i_bus.size != 2'h2 |=> o_bus_err;
  endproperty
  a_size: assert property (p_size) else $error("narrow access accepted");
endmodule
bind nvicw_ctrl nvicw_ctrl_props u_props (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
  .i_bus(i_bus), .i_core(i_core), .o_bus_err(o_bus_err), .o_irq_take(o_irq_take),
  .o_nmi_take(o_nmi_take), .o_svc_take(o_svc_take), .o_svc_imm(o_svc_imm),
  .o_stack_push(o_stack_push), .o_chain(o_chain), .o_sleeping(o_sleeping),
  .o_event_out(o_event_out), .o_event_reg(o_event_reg), .o_mask_bit(o_mask_bit),
  .o_flags(o_flags));
`default_nettype wire

/* tb/nvicw_stack_model.sv */
// Purpose: Core stacking datapath stand-in
// Assumes: Push or pop pulses start one transfer
// Notes: DELAY sets how slowly it answers
`timescale 1ns/1ns
`default_nettype none
module nvicw_stack_model
#(
  parameter int DELAY = 3
)
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_push,
  input wire logic i_pop,
  output logic o_stack_done
);
  logic [3:0] cnt_q;
  always_ff @(posedge i_sys_clk)
  begin
    o_stack_done <= 1'b0;
    if (!i_resetn)
      cnt_q <= 4'h0;
    else if (i_push || i_pop)
      cnt_q <= DELAY[3:0];
    else if (cnt_q != 4'h0)
    begin
      cnt_q <= cnt_q - 4'h1;
      o_stack_done <= (cnt_q == 4'h1); // One pulse when the transfer ends
    end
  end
endmodule
`default_nettype wire

/* tb/nvicw_ctrl_tb.sv */
// Purpose: Register, arbitration and sleep checks of the controller
// Assumes: Stacking answered by the stack model after three cycles
// Notes: Inputs change 1 ns after the rising edge
`include "nvicw_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module nvicw_ctrl_tb;
  import nvicw_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] irq = 32'h0;
  logic [31:0] pmode = 32'h00000100;
  logic nmi = 1'b0;
  nvicw_bus_req_t bus = '0;
  nvicw_core_t core_r = '0;
  nvicw_core_t core_w;
  logic sd, err, take, nmi_t, svc_t, push, pop, chain, slp, ev_o, ev_r, mask, err_v, ev_s;
  logic ch_s, pp_s;
  logic [31:0] rdata, rd_v, a;
  logic [4:0] vec;
  logic [7:0] imm;
  logic [1:0] ctl;
  logic [3:0] flags;
  int bad_count = 0;
  int comparisons = 0;
  initial forever #5 clk = ~clk;
  // Stacking done comes from the model
  always_comb
  begin
    core_w = core_r;
    core_w.stack_done = sd;
  end
  nvicw_stack_model #(.DELAY(3)) u_model (.i_sys_clk(clk), .i_resetn(rst_n), .i_push(push),
    .i_pop(pop), .o_stack_done(sd));
  nvicw_ctrl u_dut (.i_sys_clk(clk), .i_resetn(rst_n), .i_irq(irq), .i_irq_pulse_mode(pmode),
    .i_nmi(nmi), .i_bus(bus), .i_core(core_w), .o_rdata(rdata), .o_bus_err(err),
    .o_irq_take(take), .o_irq_vec(vec), .o_nmi_take(nmi_t), .o_svc_take(svc_t),
    .o_svc_imm(imm), .o_stack_push(push), .o_stack_pop(pop), .o_chain(chain),
    .o_sleeping(slp), .o_event_out(ev_o), .o_event_reg(ev_r), .o_mask_bit(mask),
    .o_control(ctl), .o_flags(flags));
  task automatic final_report;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  // One bus request; answer is read in the cycle after
  task automatic acc(input logic w, input logic [1:0] s, input logic [31:0] ad,
    input logic [31:0] d);
    bus = '{sel: 1'b1, wr: w, size: s, addr: ad, wdata: d};
    tick(1);
    rd_v = rdata;
    err_v = err;
    bus.sel = 1'b0;
    tick(1);
  endtask
  task automatic wr(input logic [31:0] ad, input logic [31:0] d);
    acc(1'b1, 2'h2, ad, d);
  endtask
  task automatic rd(input logic [31:0] ad, input logic [31:0] exp);
    acc(1'b0, 2'h2, ad, 32'h0);
    chk32(rd_v, exp);
  endtask
  function automatic nvicw_core_t mk(input int k, input logic [1:0] s, input logic [31:0] v);
    nvicw_core_t c;
    c = '0;
    c.wait_for_interrupt = (k == 0);
    c.wait_for_event = (k == 1);
    c.send_event = (k == 2);
    c.supervisor_call = (k == 3);
    c.svc_imm = v[7:0];
    c.move_to_special_reg = (k == 4);
    c.msr_sel = s;
    c.msr_val = v;
    c.dbg_req = (k == 5);
    c.done = (k == 6);
    return c;
  endfunction
  // One-cycle core strobe; event, chain and pop pulses are caught in their cycle
  task automatic cp(input int k, input logic [1:0] s, input logic [31:0] v);
    core_r = mk(k, s, v);
    tick(1);
    ev_s = ev_o;
    ch_s = chain;
    pp_s = pop;
    core_r = '0;
    tick(1);
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return take;
      1: return chain;
      2: return nmi_t;
      3: return svc_t;
      4: return slp;
      5: return pop;
      default: return ~slp;
    endcase
  endfunction
  // Bounded wait for one design output
  task automatic wt(input int k);
    int n;
    n = 0;
    while (sig(k) !== 1'b1 && n < 60)
    begin
      tick(1);
      n++;
    end
    if (n == 60)
    begin
      bad_count++;
      $display("[FAIL] %0t no answer of kind %0d", $time, k);
      final_report;
    end
  endtask
  // Handler runs, returns, and state is unstacked
  task automatic srv;
    tick(8);
    cp(6, 2'h0, 32'h0);
    chk1(pp_s, 1'b1);
    tick(8);
  endtask
  // Main sequence
  initial
  begin
    tick(6);
    rst_n = 1'b1;
    for (a = `NVICW_ADDR_EN_SET; a <= `NVICW_ADDR_PEND_CLR; a += 32'h80)
      rd(a, 32'h0);
    rd(`NVICW_ADDR_PRIO_LAST, 32'h0);
    wr(`NVICW_ADDR_EN_SET, 32'h000003F0);
    wr(`NVICW_ADDR_EN_SET, 32'h0);
    rd(`NVICW_ADDR_EN_SET, 32'h000003F0);
    wr(`NVICW_ADDR_EN_CLR, 32'h00000200);
    rd(`NVICW_ADDR_EN_CLR, 32'h000001F0);
    wr(`NVICW_ADDR_PRIO_BASE, 32'hFFFFFFFF);
    rd(`NVICW_ADDR_PRIO_BASE, 32'hC0C0C0C0);
    acc(1'b1, 2'h0, `NVICW_ADDR_PRIO_BASE, 32'h0);
    chk1(err_v, 1'b1);
    rd(`NVICW_ADDR_PRIO_BASE, 32'hC0C0C0C0);
    acc(1'b0, 2'h2, 32'hE000E300, 32'h0);
    chk1(err_v, 1'b1);
    wr(`NVICW_ADDR_PRIO_BASE + 32'h4, 32'hC0C000C0);
    cp(4, 2'h0, 32'h1);
    chk1(mask, 1'b1);
    wr(`NVICW_ADDR_PEND_SET, 32'h00000071);
    rd(`NVICW_ADDR_PEND_SET, 32'h00000071);
    cp(4, 2'h0, 32'h0);
    wt(0);
    chk32({27'h0, vec}, 32'h5);
    tick(8);
    cp(6, 2'h0, 32'h0);
    chk1(ch_s, 1'b1);
    wt(0);
    chk1(push, 1'b0);
    tick(1);
    chk32({27'h0, vec}, 32'h4);
    tick(6);
    cp(6, 2'h0, 32'h0);
    chk1(ch_s, 1'b1);
    wt(0);
    chk1(push, 1'b0);
    tick(1);
    chk32({27'h0, vec}, 32'h6);
    srv();
    rd(`NVICW_ADDR_PEND_CLR, 32'h00000001);
    wr(`NVICW_ADDR_PEND_CLR, 32'h00000001);
    rd(`NVICW_ADDR_PEND_SET, 32'h0);
    irq[7] = 1'b1;
    wt(0);
    irq[7] = 1'b0;
    chk32({27'h0, vec}, 32'h7);
    srv();
    irq[8] = 1'b1;
    tick(1);
    irq[8] = 1'b0;
    wt(0);
    chk32({27'h0, vec}, 32'h8);
    srv();
    cp(4, 2'h0, 32'h1);
    nmi = 1'b1;
    wt(2);
    nmi = 1'b0;
    srv();
    cp(3, 2'h0, 32'h000000FF);
    wt(3);
    chk32({24'h0, imm}, 32'h000000FF);
    srv();
    cp(0, 2'h0, 32'h0);
    wt(4);
    cp(5, 2'h0, 32'h0);
    wt(6);
    cp(0, 2'h0, 32'h0);
    wt(4);
    wr(`NVICW_ADDR_PEND_SET, 32'h00000010);
    wt(6);
    wr(`NVICW_ADDR_PEND_CLR, 32'h00000010);
    cp(1, 2'h0, 32'h0);
    tick(2);
    chk1(slp, 1'b0);
    cp(2, 2'h0, 32'h0);
    chk1(ev_s, 1'b1);
    chk1(ev_r, 1'b1);
    cp(4, 2'h2, 32'hA0000000);
    chk32({28'h0, flags}, 32'h0000000A);
    final_report;
  end
endmodule
`default_nettype wire
